// File: pkg/asp_regs.svh
// field positions, fixed sizes and timing counts of the serial port
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
`define ASP_DEPTH        16
`define ASP_AW           4
`define ASP_CW           5
`define ASP_WORD_MAX     4'h9
`define ASP_WORD_MIN     4'h5
`define ASP_BIT_LAST     5'h0f
`define ASP_MID_TICK     5'h07
`define ASP_STOP15_LAST  5'h17
`define ASP_STOP2_LAST   5'h1f
`define ASP_IRDA_TICKS   5'h03
`define ASP_IRDA_HOLD    5'h10
`define ASP_LIN_BRK_BASE 8'h0d
`define ASP_TOUT_MSB     6
`define ASP_GAP_LSB      8
`define ASP_GAP_MSB      15
`define ASP_ST_TOUT      0
`define ASP_ST_BRK       1
`define ASP_ST_FRM       2
`define ASP_ST_PAR       3
`define ASP_ST_RXOVF     4
`define ASP_ST_TXOVF     5
`define ASP_ST_LINBRK    6
`define ASP_ST_WAKE      7
`define ASP_ST_W         8
`endif

// File: pkg/asp_pkg.sv
// state types of the serial port
package asp_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GAP, TX_BRK} asp_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD} asp_rx_state_t;
endpackage

// File: rtl/asp_fifo.sv
// character fifo, 16 deep or one entry in the reduced setting
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_fifo (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                single_i,
  input  wire logic                push_i,
  input  wire logic [8:0]          data_i,
  input  wire logic                pop_i,
  output logic      [8:0]          data_o,
  output logic                     full_o,
  output logic                     empty_o,
  output logic      [`ASP_CW-1:0]  count_o
);
  logic [8:0]          mem_reg [0:`ASP_DEPTH-1];
  logic [`ASP_AW-1:0]  wr_reg, wr_next, rd_reg, rd_next;
  logic [`ASP_CW-1:0]  cnt_reg, cnt_next;
  logic                do_push, do_pop;

  // reduced setting keeps the same storage but caps occupancy at one
  assign full_o  = single_i ? (cnt_reg != 5'h00) : (cnt_reg == 5'h10);
  assign empty_o = (cnt_reg == 5'h00);
  assign data_o  = mem_reg[rd_reg];
  assign count_o = cnt_reg;
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;

  always_comb begin
    wr_next  = do_push ? wr_reg + 4'h1 : wr_reg;
    rd_next  = do_pop ? rd_reg + 4'h1 : rd_reg;
    cnt_next = cnt_reg + {4'h0, do_push} - {4'h0, do_pop};
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_reg  <= 4'h0;
      rd_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem_reg[wr_reg] <= data_i;
    end
  end

  AST_FIFO_CAP: assert property (@(posedge clock_i) disable iff (rst_i)
    single_i |-> cnt_reg <= 5'h01) else $error("single buffer holds more than one");
  AST_FIFO_LIMIT: assert property (@(posedge clock_i) disable iff (rst_i)
    cnt_reg <= 5'h10) else $error("fifo above sixteen entries");
endmodule // asp_fifo

// File: rtl/asp_uart.sv
// asynchronous serial port with fifos, flow control, irda, lin and rs485 modes
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_uart (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic [8:0]           tx_data_i,
  input  wire logic                 tx_valid_i,
  output logic                      tx_ready_o,
  output logic      [8:0]           rx_data_o,
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  input  wire logic [15:0]          divisor_i,
  input  wire logic [1:0]           word_len_i,
  input  wire logic                 parity_en_i,
  input  wire logic                 parity_even_i,
  input  wire logic                 parity_stick_i,
  input  wire logic [1:0]           stop_bits_i,
  input  wire logic                 fifo_single_i,
  input  wire logic [4:0]           rx_trig_level_i,
  input  wire logic [4:0]           rts_level_i,
  input  wire logic                 auto_cts_i,
  input  wire logic                 auto_rts_i,
  input  wire logic                 rts_sw_i,
  input  wire logic [15:0]          rx_timeout_control_reg_i,
  input  wire logic                 wake_en_i,
  input  wire logic                 irda_en_i,
  input  wire logic                 lin_en_i,
  input  wire logic                 lin_break_req_i,
  input  wire logic [3:0]           lin_break_len_i,
  input  wire logic                 rs485_en_i,
  input  wire logic                 rs485_auto_dir_i,
  input  wire logic [`ASP_ST_W-1:0] status_clr_i,
  input  wire logic                 serial_rx_i,
  input  wire logic                 cts_i,
  output logic                      serial_tx_o,
  output logic                      rts_o,
  output logic                      rx_req_o,
  output logic      [`ASP_ST_W-1:0] status_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  function automatic logic parity_bit(input logic [8:0] d, input logic even, input logic stick);
    parity_bit = stick ? !even : ((^d) ^ !even);
  endfunction

  asp_pkg::asp_tx_state_t tx_state_reg, tx_state_next;
  asp_pkg::asp_rx_state_t rx_state_reg, rx_state_next;
  logic [15:0] baud_cnt_reg, baud_cnt_next;
  logic        tick;
  logic [3:0]  nbits;
  logic [8:0]  wmask, rx_word;
  logic        par_on;
  logic [7:0]  gap;
  logic [6:0]  tout;
  logic [8:0]  tx_shift_reg, tx_shift_next, rx_shift_reg, rx_shift_next;
  logic [3:0]  tx_bitn_reg, tx_bitn_next, rx_bitn_reg, rx_bitn_next;
  logic [4:0]  tx_tick_reg, tx_tick_next, rx_tick_reg, rx_tick_next, tx_last;
  logic [7:0]  tx_cnt_reg, tx_cnt_next;
  logic        tx_par_reg, tx_par_next, rx_par_reg, rx_par_next;
  logic        brk_pend_reg, brk_pend_next, tx_line, tx_pop;
  logic        stx_reg, stx_next, rts_reg, rts_next;
  logic [4:0]  irda_cnt_reg, irda_cnt_next;
  logic        rx_in, rx_push, ferr_ev, perr_ev, brk_ev, rx_pop;
  logic [8:0]  tx_fifo_data, rx_fifo_data;
  logic        tx_full, tx_empty, rx_full, rx_empty;
  logic [4:0]  tx_cnt, rx_cnt;
  logic [8:0]  rx_out_data_reg, rx_out_data_next;
  logic        rx_out_valid_reg, rx_out_valid_next;
  logic [3:0]  to_tick_reg, to_tick_next;
  logic [6:0]  to_cnt_reg, to_cnt_next;
  logic        to_restart, tout_ev, wake_ev, cts_prev_reg;
  logic [`ASP_ST_W-1:0] status_reg, status_next, status_set;
  logic        rx_req_reg, rx_req_next, tx_ready_reg, tx_ready_next;

  assign nbits  = rs485_en_i ? `ASP_WORD_MAX : `ASP_WORD_MIN + {2'b00, word_len_i};
  assign wmask  = 9'h1ff >> (`ASP_WORD_MAX - nbits);
  assign par_on = parity_en_i && !rs485_en_i;
  assign gap    = rx_timeout_control_reg_i[`ASP_GAP_MSB:`ASP_GAP_LSB];
  assign tout   = rx_timeout_control_reg_i[`ASP_TOUT_MSB:0];
  // divisor 0 gives a tick every cycle; >= keeps the count bounded when the divisor drops
  assign tick   = (baud_cnt_reg >= divisor_i);
  assign baud_cnt_next = tick ? 16'h0000 : baud_cnt_reg + 16'h0001;

  asp_fifo u_tx_fifo (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .single_i (fifo_single_i),
    .push_i   (tx_valid_i),
    .data_i   (tx_data_i),
    .pop_i    (tx_pop),
    .data_o   (tx_fifo_data),
    .full_o   (tx_full),
    .empty_o  (tx_empty),
    .count_o  (tx_cnt)
  );

  asp_fifo u_rx_fifo (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .single_i (fifo_single_i),
    .push_i   (rx_push),
    .data_i   (rx_word),
    .pop_i    (rx_pop),
    .data_o   (rx_fifo_data),
    .full_o   (rx_full),
    .empty_o  (rx_empty),
    .count_o  (rx_cnt)
  );

  // transmitter
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_bitn_next  = tx_bitn_reg;
    tx_tick_next  = tx_tick_reg;
    tx_cnt_next   = tx_cnt_reg;
    tx_par_next   = tx_par_reg;
    brk_pend_next = brk_pend_reg || (lin_en_i && lin_break_req_i);
    tx_pop        = 1'b0;
    case (stop_bits_i)
      2'b01:   tx_last = `ASP_STOP15_LAST;
      2'b10:   tx_last = `ASP_STOP2_LAST;
      default: tx_last = `ASP_BIT_LAST;
    endcase
    if (tx_state_reg != asp_pkg::TX_STOP) begin
      tx_last = `ASP_BIT_LAST;
    end
    case (tx_state_reg)
      asp_pkg::TX_IDLE: begin
        tx_tick_next = 5'h00;
        if (brk_pend_reg) begin
          tx_state_next = asp_pkg::TX_BRK;
          tx_cnt_next   = `ASP_LIN_BRK_BASE + {4'h0, lin_break_len_i};
          brk_pend_next = lin_en_i && lin_break_req_i;
        end else if (!tx_empty && (!auto_cts_i || cts_i)) begin
          tx_pop        = 1'b1;
          tx_shift_next = tx_fifo_data & wmask;
          tx_par_next   = parity_bit(tx_fifo_data & wmask, parity_even_i, parity_stick_i);
          tx_state_next = asp_pkg::TX_START;
        end
      end
      default: begin
        if (tick && tx_tick_reg == tx_last) begin
          tx_tick_next = 5'h00;
          case (tx_state_reg)
            asp_pkg::TX_START: begin
              tx_state_next = asp_pkg::TX_DATA;
              tx_bitn_next  = 4'h0;
            end
            asp_pkg::TX_DATA: begin
              tx_shift_next = tx_shift_reg >> 1;
              tx_bitn_next  = tx_bitn_reg + 4'h1;
              if (tx_bitn_reg == nbits - 4'h1) begin
                tx_state_next = par_on ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
              end
            end
            asp_pkg::TX_PAR:  tx_state_next = asp_pkg::TX_STOP;
            asp_pkg::TX_STOP: begin
              tx_cnt_next   = gap;
              tx_state_next = (gap != 8'h00) ? asp_pkg::TX_GAP : asp_pkg::TX_IDLE;
            end
            default: begin
              tx_cnt_next = tx_cnt_reg - 8'h01;
              if (tx_cnt_reg == 8'h01) begin
                tx_state_next = (tx_state_reg == asp_pkg::TX_GAP) ? asp_pkg::TX_IDLE : asp_pkg::TX_STOP;
              end
            end
          endcase
        end else if (tick) begin
          tx_tick_next = tx_tick_reg + 5'h01;
        end
      end
    endcase
    case (tx_state_reg)
      asp_pkg::TX_START: tx_line = 1'b0;
      asp_pkg::TX_BRK:   tx_line = 1'b0;
      asp_pkg::TX_DATA:  tx_line = tx_shift_reg[0];
      asp_pkg::TX_PAR:   tx_line = tx_par_reg;
      default:           tx_line = 1'b1;
    endcase
    stx_next = irda_en_i ? (!tx_line && tx_tick_reg < `ASP_IRDA_TICKS) : tx_line;
    if (rs485_en_i) begin
      rts_next = rs485_auto_dir_i ? (tx_state_reg != asp_pkg::TX_IDLE) : rts_sw_i;
    end else begin
      rts_next = auto_rts_i ? (rx_cnt < rts_level_i) : rts_sw_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_state_reg <= asp_pkg::TX_IDLE;
      tx_shift_reg <= 9'h000;
      tx_bitn_reg  <= 4'h0;
      tx_tick_reg  <= 5'h00;
      tx_cnt_reg   <= 8'h00;
      tx_par_reg   <= 1'b0;
      brk_pend_reg <= 1'b0;
      stx_reg      <= 1'b1;
      rts_reg      <= 1'b0;
      baud_cnt_reg <= 16'h0000;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_shift_reg <= tx_shift_next;
      tx_bitn_reg  <= tx_bitn_next;
      tx_tick_reg  <= tx_tick_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_par_reg   <= tx_par_next;
      brk_pend_reg <= brk_pend_next;
      stx_reg      <= stx_next;
      rts_reg      <= rts_next;
      baud_cnt_reg <= baud_cnt_next;
    end
  end

  // receiver; a sir pulse is stretched over one bit so mid-bit sampling still sees it
  assign rx_in   = irda_en_i ? (irda_cnt_reg == 5'h00) : serial_rx_i;
  assign rx_word = rx_shift_reg >> (`ASP_WORD_MAX - nbits);

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_shift_next = rx_shift_reg;
    rx_bitn_next  = rx_bitn_reg;
    rx_tick_next  = rx_tick_reg;
    rx_par_next   = rx_par_reg;
    rx_push       = 1'b0;
    ferr_ev       = 1'b0;
    perr_ev       = 1'b0;
    brk_ev        = 1'b0;
    if (irda_en_i && serial_rx_i) begin
      irda_cnt_next = `ASP_IRDA_HOLD;
    end else if (tick && irda_cnt_reg != 5'h00) begin
      irda_cnt_next = irda_cnt_reg - 5'h01;
    end else begin
      irda_cnt_next = irda_cnt_reg;
    end
    case (rx_state_reg)
      asp_pkg::RX_IDLE: begin
        rx_tick_next = 5'h00;
        if (!rx_in) begin
          rx_state_next = asp_pkg::RX_START;
        end
      end
      asp_pkg::RX_START: begin
        if (tick && rx_tick_reg == `ASP_MID_TICK) begin
          rx_tick_next  = 5'h00;
          rx_bitn_next  = 4'h0;
          rx_shift_next = 9'h000;
          rx_state_next = rx_in ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
        end else if (tick) begin
          rx_tick_next = rx_tick_reg + 5'h01;
        end
      end
      asp_pkg::RX_HOLD: begin
        if (rx_in) begin
          rx_state_next = asp_pkg::RX_IDLE;
        end
      end
      default: begin
        if (tick && rx_tick_reg == `ASP_BIT_LAST) begin
          rx_tick_next = 5'h00;
          if (rx_state_reg == asp_pkg::RX_DATA) begin
            rx_shift_next = {rx_in, rx_shift_reg[8:1]};
            rx_bitn_next  = rx_bitn_reg + 4'h1;
            if (rx_bitn_reg == nbits - 4'h1) begin
              rx_state_next = par_on ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
            end
          end else if (rx_state_reg == asp_pkg::RX_PAR) begin
            rx_par_next   = rx_in;
            rx_state_next = asp_pkg::RX_STOP;
          end else begin
            // all-zero character with a low stop bit and no high parity bit is a break, not data
            brk_ev  = !rx_in && rx_word == 9'h000 && !(par_on && rx_par_reg);
            rx_push = !brk_ev;
            ferr_ev = !rx_in && !brk_ev;
            perr_ev = !brk_ev && par_on && rx_par_reg != parity_bit(rx_word, parity_even_i, parity_stick_i);
            rx_state_next = rx_in ? asp_pkg::RX_IDLE : asp_pkg::RX_HOLD;
          end
        end else if (tick) begin
          rx_tick_next = rx_tick_reg + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_state_reg <= asp_pkg::RX_IDLE;
      rx_shift_reg <= 9'h000;
      rx_bitn_reg  <= 4'h0;
      rx_tick_reg  <= 5'h00;
      rx_par_reg   <= 1'b0;
      irda_cnt_reg <= 5'h00;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_shift_reg <= rx_shift_next;
      rx_bitn_reg  <= rx_bitn_next;
      rx_tick_reg  <= rx_tick_next;
      rx_par_reg   <= rx_par_next;
      irda_cnt_reg <= irda_cnt_next;
    end
  end

  // output stage, timeout and sticky status
  assign rx_pop     = (!rx_out_valid_reg || rx_ready_i) && !rx_empty;
  assign to_restart = (rx_empty && !rx_out_valid_reg) || rx_state_reg != asp_pkg::RX_IDLE
                      || rx_push || rx_pop || tout == 7'h00;
  assign tout_ev    = !to_restart && tick && to_tick_reg == 4'hf && to_cnt_reg + 7'h01 == tout;
  assign wake_ev    = wake_en_i && (cts_i != cts_prev_reg);

  always_comb begin
    rx_out_valid_next = rx_pop || (rx_out_valid_reg && !rx_ready_i);
    rx_out_data_next  = rx_pop ? rx_fifo_data : rx_out_data_reg;
    to_tick_next      = to_tick_reg;
    to_cnt_next       = to_cnt_reg;
    if (to_restart) begin
      to_tick_next = 4'h0;
      to_cnt_next  = 7'h00;
    end else if (tick && to_cnt_reg != tout) begin
      to_tick_next = to_tick_reg + 4'h1;
      if (to_tick_reg == 4'hf) begin
        to_cnt_next = to_cnt_reg + 7'h01;
      end
    end
    status_set                 = '0;
    status_set[`ASP_ST_TOUT]   = tout_ev;
    status_set[`ASP_ST_BRK]    = brk_ev;
    status_set[`ASP_ST_FRM]    = ferr_ev;
    status_set[`ASP_ST_PAR]    = perr_ev;
    status_set[`ASP_ST_RXOVF]  = rx_push && rx_full;
    status_set[`ASP_ST_TXOVF]  = tx_valid_i && tx_full;
    status_set[`ASP_ST_LINBRK] = brk_ev && lin_en_i;
    status_set[`ASP_ST_WAKE]   = wake_ev;
    // set wins over a clear in the same cycle so no event is lost
    status_next   = (status_reg & ~status_clr_i) | status_set;
    rx_req_next   = (rx_cnt != 5'h00) && (rx_cnt >= rx_trig_level_i);
    tx_ready_next = !tx_full;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_out_valid_reg <= 1'b0;
      rx_out_data_reg  <= 9'h000;
      to_tick_reg      <= 4'h0;
      to_cnt_reg       <= 7'h00;
      status_reg       <= '0;
      rx_req_reg       <= 1'b0;
      tx_ready_reg     <= 1'b0;
      cts_prev_reg     <= cts_i; // follows the pin in reset: no false wake edge on release
    end else begin
      rx_out_valid_reg <= rx_out_valid_next;
      rx_out_data_reg  <= rx_out_data_next;
      to_tick_reg      <= to_tick_next;
      to_cnt_reg       <= to_cnt_next;
      status_reg       <= status_next;
      rx_req_reg       <= rx_req_next;
      tx_ready_reg     <= tx_ready_next;
      cts_prev_reg     <= cts_i;
    end
  end

  assign tx_ready_o  = tx_ready_reg;
  assign rx_data_o   = rx_out_data_reg;
  assign rx_valid_o  = rx_out_valid_reg;
  assign serial_tx_o = stx_reg;
  assign rts_o       = rts_reg;
  assign rx_req_o    = rx_req_reg;
  assign status_o    = status_reg;

  AST_CTS_HOLD: assert property (tx_pop |-> (!auto_cts_i || cts_i)) else $error("sent while cts low");
  AST_RX_REQ: assert property (rx_cnt >= rx_trig_level_i && rx_cnt != 5'h00 |=> rx_req_o)
    else $error("receive request missing");
  AST_BAUD_GAP: assert property (tick && divisor_i != 16'h0000 |=> !tick || divisor_i != $past(divisor_i))
    else $error("baud ticks too close");
  AST_WAKE: assert property (wake_en_i && cts_i != $past(cts_i) && !$past(rst_i) |=> status_o[`ASP_ST_WAKE])
    else $error("cts change gave no wake");
  AST_TOUT_DATA: assert property ($rose(status_o[`ASP_ST_TOUT]) |-> $past(rx_state_reg) == asp_pkg::RX_IDLE)
    else $error("timeout while receiving");
  AST_GAP_LEN: assert property ($rose(tx_state_reg == asp_pkg::TX_GAP) |-> tx_cnt_reg == $past(gap) && $past(gap) != 8'h00)
    else $error("gap length wrong");
  AST_FRAME_FLAG: assert property (ferr_ev |=> status_o[`ASP_ST_FRM]) else $error("frame error lost");
  AST_TX_PARITY: assert property (tx_state_reg == asp_pkg::TX_PAR && !irda_en_i |=> serial_tx_o == $past(tx_par_reg))
    else $error("parity bit wrong");
  AST_STOP_LEN: assert property (tx_state_reg == asp_pkg::TX_STOP && tx_tick_reg > `ASP_BIT_LAST |-> stop_bits_i != 2'b00)
    else $error("stop longer than one bit");
  AST_IRDA_PULSE: assert property (irda_en_i && $past(irda_en_i) && serial_tx_o |-> $past(tx_tick_reg) < `ASP_IRDA_TICKS)
    else $error("sir pulse too long");
  AST_LIN_BRK: assert property (tx_state_reg == asp_pkg::TX_BRK && !irda_en_i |=> !serial_tx_o)
    else $error("break field not low");
  AST_START_LOW: assert property (tx_state_reg == asp_pkg::TX_START && !irda_en_i |=> !serial_tx_o)
    else $error("start bit not low");
  AST_RS485_DIR: assert property (rs485_en_i && rs485_auto_dir_i && tx_state_reg != asp_pkg::TX_IDLE |=> rts_o)
    else $error("direction enable low while sending");
  COV_RX_CHAR: cover property (rx_push && !rx_full);
  COV_LIN_BRK: cover property (brk_ev && lin_en_i);
  COV_TX_GAP: cover property (tx_state_reg == asp_pkg::TX_GAP);
  COV_WAKE: cover property (wake_ev);
endmodule // asp_uart

// File: sim/asp_remote.sv
// remote serial device that echoes every bit it hears back to the port
`timescale 1ns/1ps
module asp_remote (
  input  wire logic clock_i,
  input  wire logic line_i,
  input  wire logic rts_i,
  input  wire logic corrupt_i,
  output logic      line_o,
  output logic      cts_o
);
  // one-clock echo; corrupt_i flips bits for error cases
  always_ff @(posedge clock_i) begin
    line_o <= line_i ^ corrupt_i;
  end
  // clears the port to send only while the port says it can take more; the echo itself never waits
  assign cts_o = rts_i;
endmodule // asp_remote

// File: sim/asp_uart_bench.sv
// self-checking bench of the serial port looped through an echoing remote device
`timescale 1ns/1ps
module asp_uart_bench;
  logic        clock_i = 0, rst_i = 1, tv = 0, rr = 0, corrupt = 0, skip = 0, ir = 0, ln = 0, lb = 0;
  logic [8:0]  td = '0, rx_data_o;
  logic [1:0]  wl = 0, sb = 0;
  logic        pe = 0, pv = 0, ps = 0, sg = 0, ac = 0, ar = 0, wk = 0, r485 = 0;
  logic [4:0]  trig = 0, rl = 0;
  logic [3:0]  bl = 0;
  logic [15:0] dv = '0, tor = '0;
  logic [7:0]  clr = '0, status_o;
  logic        tx_ready_o, rx_valid_o, serial_tx_o, rts_o, rx_req_o, line, cts;
  logic [8:0]  q[$];
  int          num_errors = 0, checked = 0, seed = 85686;

  asp_uart DUT (.clock_i(clock_i), .rst_i(rst_i), .tx_data_i(td), .tx_valid_i(tv), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rr), .divisor_i(dv), .word_len_i(wl),
    .parity_en_i(pe), .parity_even_i(pv), .parity_stick_i(ps), .stop_bits_i(sb), .fifo_single_i(sg),
    .rx_trig_level_i(trig), .rts_level_i(rl), .auto_cts_i(ac), .auto_rts_i(ar), .rts_sw_i(ac | wk),
    .rx_timeout_control_reg_i(tor), .wake_en_i(wk), .irda_en_i(ir), .lin_en_i(ln), .lin_break_req_i(lb),
    .lin_break_len_i(bl), .rs485_en_i(r485), .rs485_auto_dir_i(r485 & ~ac), .status_clr_i(clr),
    .serial_rx_i(line), .cts_i(cts), .serial_tx_o(serial_tx_o), .rts_o(rts_o), .rx_req_o(rx_req_o),
    .status_o(status_o));
  asp_remote partner (.clock_i(clock_i), .line_i(serial_tx_o), .rts_i(rts_o), .corrupt_i(corrupt),
    .line_o(line), .cts_o(cts));

  initial forever #2 clock_i = ~clock_i;

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("counts: %0d checks, %0d errors", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // single-entry fifo needs the stale ready flag to settle between pushes
  task automatic push(input logic [8:0] d, input logic [8:0] flip, input bit wait_rdy);
    int n;
    n = 0;
    while (wait_rdy && tx_ready_o !== 1'b1 && n++ < 5000) @(negedge clock_i);
    check(n > 5000, 1'b0);
    @(posedge clock_i);
    td <= d;
    tv <= 1'b1;
    q.push_back((r485 ? d : d & ((9'h001 << (5 + wl)) - 9'h001)) ^ flip);
    @(posedge clock_i);
    tv <= 1'b0;
    if (wait_rdy) repeat (2) @(posedge clock_i);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (q.size() != 0 && n++ < 20000) @(negedge clock_i);
    check(q.size(), 0);
    // let the last stop bits and gap finish before the setup changes
    repeat (250) @(negedge clock_i);
  endtask

  always @(posedge clock_i) rr <= $random(seed);

  always @(posedge clock_i) begin
    if (!rst_i && rx_valid_o && rr) begin
      if (skip) q.delete();
      else check(rx_data_o, q.size() != 0 ? q.pop_front() : 12'hfff);
    end
  end

  initial begin
    int n;
    @(negedge clock_i);
    check({serial_tx_o, rts_o, rx_valid_o, rx_req_o, status_o}, 12'h800);
    @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clock_i);
      {wl, sb, pe, pv, ps, sg, ac, ar, wk} <= $random(seed);
      r485 <= (i % 4 == 3);
      dv <= i % 2;
      trig <= $random(seed);
      rl <= 5'h02 + i;
      tor <= {6'h00, i[1:0], 8'h04};
      clr <= 8'hff;
      @(posedge clock_i);
      clr <= 8'h00;
      repeat (3) push($random(seed), 9'h000, 1'b1);
      drain();
      check({tx_ready_o, rx_req_o, rts_o}, {2'b10, (r485 ? ac : (ar | ac | wk))});
      $display("test %0d done", i);
    end
    @(posedge clock_i);
    {wl, pe, pv, ps, sg, r485, dv, clr} <= {2'h3, 3'b110, 2'b00, 16'h0000, 8'hff};
    @(posedge clock_i);
    clr <= 8'h00;
    push(9'h0a5, 9'h001, 1'b1);
    // flip the echo across the middle of the first data bit
    repeat (20) @(posedge clock_i);
    corrupt <= 1'b1;
    repeat (10) @(posedge clock_i);
    corrupt <= 1'b0;
    drain();
    check(status_o[3], 1'b1);
    $display("parity error test done");
    @(posedge clock_i);
    {ln, clr} <= {1'b1, 8'hff};
    bl <= $random(seed);
    @(posedge clock_i);
    {clr, lb} <= {8'h00, 1'b1};
    @(posedge clock_i);
    lb <= 1'b0;
    n = 0;
    while (serial_tx_o !== 1'b0 && n++ < 100) @(negedge clock_i);
    n = 0;
    while (serial_tx_o === 1'b0 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    check(n, 16 * (13 + bl));
    repeat (200) @(negedge clock_i);
    check({status_o[6], status_o[1], status_o[2]}, 3'b110);
    $display("lin break test done");
    @(posedge clock_i);
    {ln, ir, skip, clr} <= {3'b011, 8'hff};
    // switching the line coding can fake a start bit; let it flush
    repeat (300) @(posedge clock_i);
    {skip, clr} <= 9'h000;
    push($random(seed), 9'h000, 1'b1);
    drain();
    check(status_o[3:2], 2'b00);
    $display("irda test done");
    @(posedge clock_i);
    {sg, skip, ir} <= 3'b110;
    repeat (3) push(9'h03c, 9'h000, 1'b0);
    repeat (3) @(negedge clock_i);
    check(status_o[5], 1'b1);
    repeat (3000) @(posedge clock_i);
    $display("overflow test done");
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge clock_i);
    num_errors++;
    stop_test();
  end
endmodule // asp_uart_bench
